// ==== fsam_defines.svh ====
// Purpose: offsets, field positions, reset values and mapping constants of the segment mapper
// Assumes: included by bare name from every file that needs it
// Notes: definitions only
`ifndef FSAM_DEFINES_SVH
`define FSAM_DEFINES_SVH

// register byte offsets
`define FSAM_CFG_OFS 12'h000
`define FSAM_CTRL_OFS 12'h004
`define FSAM_STAT_OFS 12'h008

// configuration field positions
`define FSAM_UPPER_HI 30
`define FSAM_UPPER_LO 28
`define FSAM_USER_HI 27
`define FSAM_USER_LO 25
`define FSAM_KSEG0_HI 2
`define FSAM_KSEG0_LO 0
`define FSAM_CFG_MASK 32'h7E00_0007

// control and status field positions
`define FSAM_CTRL_ELVL_BIT 0
`define FSAM_STAT_CACHED_BIT 4
`define FSAM_STAT_ADDRERR_BIT 5
`define FSAM_STAT_ELVL_BIT 8

// reset values: every attribute field starts uncached
`define FSAM_CFG_RST 32'h2400_0002
`define FSAM_CTRL_RST 1'h0

// attribute encodings
`define FSAM_CCA_UNCACHED 3'h2
`define FSAM_CCA_CACHED 3'h3

// physical mapping: user offset applies while the error level flag is clear, kernel mask in kseg0 and kseg1 only
`define FSAM_USEG_PHYS_OFS 32'h4000_0000
`define FSAM_KSEG01_MASK 32'h1FFF_FFFF

`endif

// ==== fsam_pfc_model.sv ====
// Purpose: prefetch cache stand-in that consumes the forwarded attribute fields
// Assumes: fetch address comes from the bench
// Notes: behavioural; only decides whether a flash fetch would be cached
`timescale 1ns/10ps

module fsam_pfc_model (
	// fetch request
	input wire logic [31:0] fetch_vaddr,
	// forwarded attributes
	input wire logic [2:0] user_attr,
	input wire logic [2:0] kseg0_attr,
	input wire logic [2:0] upper_attr,
	// decision
	output logic fetch_cached
);
	// only the cached code counts, any other value means uncached
	always_comb begin
		case (fetch_vaddr[31:29])
			3'h4: fetch_cached = (kseg0_attr == 3'h3);
			3'h5: fetch_cached = 1'h0;
			3'h6, 3'h7: fetch_cached = (upper_attr == 3'h3);
			default: fetch_cached = (user_attr == 3'h3);
		endcase
	end
endmodule

// ==== fsam_pkg.sv ====
// Purpose: types shared by the segment mapper files
// Assumes: nothing
// Notes: constants live in fsam_defines.svh
package fsam_pkg;

	typedef enum logic [2:0] {
		seg_useg,
		seg_kseg0,
		seg_kseg1,
		seg_kseg2,
		seg_kseg3
	} fsam_seg_t;

	typedef enum logic [1:0] {
		size_byte,
		size_half,
		size_word
	} fsam_size_t;

endpackage

// ==== fsam_top.sv ====
// Purpose: fixed segment address mapper with APB configuration registers
// Assumes: requests come from core logic on pclk; one request per cycle at most
// Notes: result registered one cycle after the request
`timescale 1ns/10ps
`include "fsam_defines.svh"

module fsam_top (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// translation request
	input wire logic req_valid,
	input wire logic [31:0] req_vaddr,
	input wire fsam_pkg::fsam_size_t req_size,
	input wire logic req_user,
	// translation result
	output logic rsp_valid,
	output logic [31:0] rsp_paddr,
	output logic rsp_cacheable,
	output logic rsp_addr_err,
	output fsam_pkg::fsam_seg_t rsp_seg,
	// attributes to prefetch cache
	output logic [2:0] pfc_user_seg_cache_attr,
	output logic [2:0] pfc_kseg0_cache_attr,
	output logic [2:0] pfc_upper_kseg_cache_attr
);

	logic [31:0] cfg_q;
	logic error_level_flag_q;
	logic [31:0] prdata_q;
	logic rsp_valid_q;
	logic [31:0] rsp_paddr_q;
	logic rsp_cacheable_q;
	logic rsp_addr_err_q;
	fsam_pkg::fsam_seg_t rsp_seg_q;
	logic [2:0] user_seg_cache_attr;
	logic [2:0] kseg0_cache_attr;
	logic [2:0] upper_kseg_cache_attr;
	fsam_pkg::fsam_seg_t xl_seg;
	logic [31:0] xl_paddr;
	logic xl_cacheable;
	logic xl_addr_err;
	logic setup;
	logic access;
	logic mapped;
	logic [31:0] rd_mux;

	assign user_seg_cache_attr = cfg_q[`FSAM_USER_HI:`FSAM_USER_LO];
	assign kseg0_cache_attr = cfg_q[`FSAM_KSEG0_HI:`FSAM_KSEG0_LO];
	assign upper_kseg_cache_attr = cfg_q[`FSAM_UPPER_HI:`FSAM_UPPER_LO];

	// apb slave
	assign setup = psel & ~penable;
	assign access = psel & penable;
	assign mapped = (paddr == `FSAM_CFG_OFS) | (paddr == `FSAM_CTRL_OFS) |
		(paddr == `FSAM_STAT_OFS);
	// zero wait: read data is captured in setup, so access can end at once
	assign pready = 1'b1;
	assign pslverr = access & ~mapped;

	always_comb begin
		rd_mux = 32'h0000_0000;
		case (paddr)
			`FSAM_CFG_OFS: rd_mux = cfg_q;
			`FSAM_CTRL_OFS: rd_mux[`FSAM_CTRL_ELVL_BIT] = error_level_flag_q;
			`FSAM_STAT_OFS: begin
				rd_mux[2:0] = rsp_seg_q;
				rd_mux[`FSAM_STAT_CACHED_BIT] = rsp_cacheable_q;
				rd_mux[`FSAM_STAT_ADDRERR_BIT] = rsp_addr_err_q;
				rd_mux[`FSAM_STAT_ELVL_BIT] = error_level_flag_q;
			end
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h0000_0000;
		end else if (setup && !pwrite) begin
			prdata_q <= rd_mux;
		end
	end
	assign prdata = prdata_q;

	// reserved configuration bits are not stored and read zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_q <= `FSAM_CFG_RST;
		end else if (access && pwrite && paddr == `FSAM_CFG_OFS) begin
			cfg_q <= pwdata & `FSAM_CFG_MASK;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			error_level_flag_q <= `FSAM_CTRL_RST;
		end else if (access && pwrite && paddr == `FSAM_CTRL_OFS) begin
			error_level_flag_q <= pwdata[`FSAM_CTRL_ELVL_BIT];
		end
	end

	// translation
	fsam_translate u_translate (
		.vaddr(req_vaddr),
		.size(req_size),
		.user_mode(req_user),
		.error_level_flag(error_level_flag_q),
		.user_seg_cache_attr(user_seg_cache_attr),
		.kseg0_cache_attr(kseg0_cache_attr),
		.upper_kseg_cache_attr(upper_kseg_cache_attr),
		.seg(xl_seg),
		.paddr(xl_paddr),
		.cacheable(xl_cacheable),
		.addr_err(xl_addr_err)
	);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rsp_valid_q <= 1'b0;
		end else begin
			rsp_valid_q <= req_valid;
		end
	end

	// result fields hold the last translation, which status reads back except the physical address
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rsp_paddr_q <= 32'h0000_0000;
			rsp_cacheable_q <= 1'b0;
			rsp_addr_err_q <= 1'b0;
			rsp_seg_q <= fsam_pkg::seg_useg;
		end else if (req_valid) begin
			rsp_paddr_q <= xl_paddr;
			rsp_cacheable_q <= xl_cacheable;
			rsp_addr_err_q <= xl_addr_err;
			rsp_seg_q <= xl_seg;
		end
	end

	assign rsp_valid = rsp_valid_q;
	assign rsp_paddr = rsp_paddr_q;
	assign rsp_cacheable = rsp_cacheable_q;
	assign rsp_addr_err = rsp_addr_err_q;
	assign rsp_seg = rsp_seg_q;

	// fields go straight from the register so the cache sees writes at once
	assign pfc_user_seg_cache_attr = user_seg_cache_attr;
	assign pfc_kseg0_cache_attr = kseg0_cache_attr;
	assign pfc_upper_kseg_cache_attr = upper_kseg_cache_attr;

	// assertions
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	user_attr_a: assert property (
		req_valid && !req_vaddr[31] && !error_level_flag_q |=>
		rsp_cacheable == ($past(user_seg_cache_attr) == `FSAM_CCA_CACHED))
		else $error("user segment cacheability wrong");

	elvl_uncached_a: assert property (
		req_valid && !req_vaddr[31] && error_level_flag_q |=> !rsp_cacheable)
		else $error("user segment cached while error level set");

	kseg0_attr_a: assert property (
		req_valid && req_vaddr[31:29] == 3'h4 |=>
		rsp_cacheable == ($past(kseg0_cache_attr) == `FSAM_CCA_CACHED) &&
		rsp_seg == fsam_pkg::seg_kseg0)
		else $error("first kernel segment cacheability wrong");

	kseg1_uncached_a: assert property (
		req_valid && req_vaddr[31:29] == 3'h5 |=> !rsp_cacheable)
		else $error("second kernel segment cached");

	upper_attr_a: assert property (
		req_valid && req_vaddr[31:30] == 2'h3 |=>
		rsp_cacheable == ($past(upper_kseg_cache_attr) == `FSAM_CCA_CACHED))
		else $error("upper kernel segment cacheability wrong");

	addr_err_only_a: assert property (
		req_valid && req_size == fsam_pkg::size_word && req_vaddr[1:0] == 2'h0 &&
		!req_user |=> rsp_valid && !rsp_addr_err)
		else $error("fault raised on a legal kernel access");

	elvl_passthru_a: assert property (
		req_valid && !req_vaddr[31] && error_level_flag_q |=>
		rsp_paddr == $past(req_vaddr))
		else $error("user address altered while error level set");

	attr_forward_a: assert property (
		access && pwrite && paddr == `FSAM_CFG_OFS |=>
		pfc_kseg0_cache_attr == $past(pwdata[2:0]) &&
		pfc_upper_kseg_cache_attr == $past(pwdata[30:28]))
		else $error("attributes not forwarded after write");

	kseg_common_a: assert property (
		req_valid && req_vaddr[31:30] == 2'h2 |=>
		rsp_paddr == ($past(req_vaddr) & `FSAM_KSEG01_MASK))
		else $error("lower kernel segments not in common region");

	useg_mapped_c: cover property (req_valid && !req_vaddr[31] && !error_level_flag_q);
	elvl_useg_c: cover property (req_valid && !req_vaddr[31] && error_level_flag_q);
	cached_kseg0_c: cover property (rsp_valid && rsp_cacheable && rsp_seg == fsam_pkg::seg_kseg0);
	addr_err_c: cover property (rsp_valid && rsp_addr_err);

endmodule

// ==== fsam_translate.sv ====
// Purpose: combinational segment decode, physical mapping and cacheability
// Assumes: attribute fields come from the configuration register
// Notes: no lookup state, so no miss can ever arise
`timescale 1ns/10ps
`include "fsam_defines.svh"

module fsam_translate (
	// request
	input wire logic [31:0] vaddr,
	input wire fsam_pkg::fsam_size_t size,
	input wire logic user_mode,
	// configuration
	input wire logic error_level_flag,
	input wire logic [2:0] user_seg_cache_attr,
	input wire logic [2:0] kseg0_cache_attr,
	input wire logic [2:0] upper_kseg_cache_attr,
	// result
	output fsam_pkg::fsam_seg_t seg,
	output logic [31:0] paddr,
	output logic cacheable,
	output logic addr_err
);

	logic misaligned;

	always_comb begin
		seg = fsam_pkg::seg_useg;
		paddr = vaddr;
		cacheable = 1'b0;
		if (!vaddr[31]) begin
			seg = fsam_pkg::seg_useg;
			if (error_level_flag) begin
				paddr = vaddr;
				cacheable = 1'b0;
			end else begin
				paddr = vaddr + `FSAM_USEG_PHYS_OFS;
				cacheable = (user_seg_cache_attr == `FSAM_CCA_CACHED);
			end
		end else begin
			case (vaddr[30:29])
				2'h0: begin
					seg = fsam_pkg::seg_kseg0;
					paddr = vaddr & `FSAM_KSEG01_MASK;
					cacheable = (kseg0_cache_attr == `FSAM_CCA_CACHED);
				end
				2'h1: begin
					seg = fsam_pkg::seg_kseg1;
					paddr = vaddr & `FSAM_KSEG01_MASK;
					cacheable = 1'b0;
				end
				2'h2: begin
					seg = fsam_pkg::seg_kseg2;
					cacheable = (upper_kseg_cache_attr == `FSAM_CCA_CACHED);
				end
				default: begin
					seg = fsam_pkg::seg_kseg3;
					cacheable = (upper_kseg_cache_attr == `FSAM_CCA_CACHED);
				end
			endcase
		end
	end

	// only alignment and privilege faults exist; translation never misses
	always_comb begin
		case (size)
			fsam_pkg::size_half: misaligned = vaddr[0];
			fsam_pkg::size_word: misaligned = |vaddr[1:0];
			default: misaligned = 1'b0;
		endcase
		addr_err = misaligned | (user_mode & vaddr[31]);
	end

endmodule

// ==== testbench.sv ====
// Purpose: self-checking bench of the segment mapper
// Assumes: zero-wait apb slave per hand-over, but waits are bounded anyway
// Notes: ordinary translations are table rows, edge cases follow the loop
`timescale 1ns/10ps
`include "fsam_defines.svh"
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin errors++; \
	$display("Error %s exp %0h got %0h", n, e, g); end end

module testbench;
	typedef struct packed {
		logic [31:0] cfg;
		logic elvl;
		logic [31:0] va;
		logic [1:0] sz;
		logic usr;
		logic [31:0] pa;
		logic ca;
		logic [2:0] sg;
		logic er;
	} fsam_row_t;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, req_valid, req_user, er;
	logic rsp_valid, rsp_cacheable, rsp_addr_err, fetch_cached;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, req_vaddr, rsp_paddr, fetch_vaddr, rd;
	logic [2:0] pfc_user_seg_cache_attr, pfc_kseg0_cache_attr, pfc_upper_kseg_cache_attr;
	fsam_pkg::fsam_size_t req_size;
	fsam_pkg::fsam_seg_t rsp_seg;
	int errors, samples_checked, cycles;
	fsam_row_t rows[10] = '{
		'{32'h3600_0003, 1'h0, 32'h0000_1000, 2'h2, 1'h1, 32'h4000_1000, 1'h1, 3'h0, 1'h0},
		'{32'h2400_0002, 1'h0, 32'h0000_1000, 2'h2, 1'h1, 32'h4000_1000, 1'h0, 3'h0, 1'h0},
		'{32'h3600_0003, 1'h1, 32'h0000_1000, 2'h2, 1'h0, 32'h0000_1000, 1'h0, 3'h0, 1'h0},
		'{32'h2400_0003, 1'h0, 32'h8000_1000, 2'h2, 1'h0, 32'h0000_1000, 1'h1, 3'h1, 1'h0},
		'{32'h3600_0003, 1'h0, 32'hA000_1000, 2'h2, 1'h0, 32'h0000_1000, 1'h0, 3'h2, 1'h0},
		'{32'h3400_0002, 1'h0, 32'hC000_0004, 2'h2, 1'h0, 32'hC000_0004, 1'h1, 3'h3, 1'h0},
		'{32'h3400_0002, 1'h0, 32'hE000_0008, 2'h2, 1'h0, 32'hE000_0008, 1'h1, 3'h4, 1'h0},
		'{32'h3600_0003, 1'h0, 32'h7FFF_FFFF, 2'h0, 1'h0, 32'hBFFF_FFFF, 1'h1, 3'h0, 1'h0},
		'{32'h3600_0003, 1'h0, 32'h8000_0001, 2'h1, 1'h0, 32'h0000_0001, 1'h1, 3'h1, 1'h1},
		'{32'h3600_0003, 1'h0, 32'h8000_0000, 2'h2, 1'h1, 32'h0000_0000, 1'h1, 3'h1, 1'h1}
	};

	fsam_top u_fsam_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .req_valid(req_valid), .req_vaddr(req_vaddr), .req_size(req_size),
		.req_user(req_user), .rsp_valid(rsp_valid), .rsp_paddr(rsp_paddr),
		.rsp_cacheable(rsp_cacheable), .rsp_addr_err(rsp_addr_err), .rsp_seg(rsp_seg),
		.pfc_user_seg_cache_attr(pfc_user_seg_cache_attr),
		.pfc_kseg0_cache_attr(pfc_kseg0_cache_attr),
		.pfc_upper_kseg_cache_attr(pfc_upper_kseg_cache_attr));
	fsam_pfc_model u_fsam_pfc_model (.fetch_vaddr(fetch_vaddr),
		.user_attr(pfc_user_seg_cache_attr), .kseg0_attr(pfc_kseg0_cache_attr),
		.upper_attr(pfc_upper_kseg_cache_attr), .fetch_cached(fetch_cached));

	task stop_test();
		if (errors == 0 && samples_checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// setup, then access until pready; the answer is taken at that edge only
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		@(posedge pclk);
		while (pready !== 1'h1 && n < 50) begin
			@(posedge pclk);
			n++;
		end
		if (n >= 50) begin
			errors++;
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		#1;
	endtask

	task req(input logic [31:0] v, input logic [1:0] s, input logic u);
		@(posedge pclk);
		req_valid <= 1'h1;
		req_vaddr <= v;
		req_size <= fsam_pkg::fsam_size_t'(s);
		req_user <= u;
		@(posedge pclk);
		req_valid <= 1'h0;
		#1;
	endtask

	initial begin
		pclk = 1'h0;
		forever #5 pclk = ~pclk;
	end

	always @(posedge pclk) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			stop_test();
		end
	end

	initial begin
		{presetn, psel, penable, pwrite, req_valid, req_user} = 6'h0;
		{paddr, pwdata, req_vaddr, fetch_vaddr} = '0;
		req_size = fsam_pkg::size_word;
		repeat (6) @(posedge pclk);
		presetn <= 1'h1;
		apb(1'h0, `FSAM_CFG_OFS, 32'h0);
		`CHK("cfg_rst", `FSAM_CFG_RST, rd)
		`CHK("pfc_user_rst", 3'h2, pfc_user_seg_cache_attr)
		foreach (rows[i]) begin
			apb(1'h1, `FSAM_CFG_OFS, rows[i].cfg);
			apb(1'h1, `FSAM_CTRL_OFS, {31'h0, rows[i].elvl});
			`CHK("pfc_user", rows[i].cfg[27:25], pfc_user_seg_cache_attr)
			`CHK("pfc_kseg0", rows[i].cfg[2:0], pfc_kseg0_cache_attr)
			`CHK("pfc_upper", rows[i].cfg[30:28], pfc_upper_kseg_cache_attr)
			req(rows[i].va, rows[i].sz, rows[i].usr);
			`CHK("rsp_valid", 1'h1, rsp_valid)
			`CHK("paddr", rows[i].pa, rsp_paddr)
			`CHK("cacheable", rows[i].ca, rsp_cacheable)
			`CHK("seg", rows[i].sg, rsp_seg)
			`CHK("addr_err", rows[i].er, rsp_addr_err)
			@(posedge pclk);
			#1;
			`CHK("rsp_pulse", 1'h0, rsp_valid)
			apb(1'h0, `FSAM_STAT_OFS, 32'h0);
			`CHK("status", {23'h0, rows[i].elvl, 2'h0, rows[i].er, rows[i].ca, 1'h0,
				rows[i].sg}, rd)
			apb(1'h0, `FSAM_CTRL_OFS, 32'h0);
			`CHK("ctrl", {31'h0, rows[i].elvl}, rd)
		end
		apb(1'h1, `FSAM_CTRL_OFS, 32'h0);
		@(posedge pclk);
		fetch_vaddr <= 32'hC000_0000;
		#1;
		`CHK("pfc_fetch", 1'h1, fetch_cached)
		// back to back: kseg1 then user segment in adjacent cycles
		@(posedge pclk);
		req_valid <= 1'h1;
		req_vaddr <= 32'hA000_0010;
		req_user <= 1'h0;
		@(posedge pclk);
		req_vaddr <= 32'h0000_0020;
		#1;
		`CHK("b2b_a", 32'h0000_0010, rsp_paddr)
		@(posedge pclk);
		req_valid <= 1'h0;
		#1;
		`CHK("b2b_valid", 1'h1, rsp_valid)
		`CHK("b2b_b", 32'h4000_0020, rsp_paddr)
		`CHK("b2b_b_ca", 1'h1, rsp_cacheable)
		apb(1'h1, `FSAM_CFG_OFS, 32'hFFFF_FFFF);
		apb(1'h0, `FSAM_CFG_OFS, 32'h0);
		`CHK("cfg_mask", `FSAM_CFG_MASK, rd)
		`CHK("slverr_ok", 1'h0, er)
		apb(1'h1, 12'h00C, 32'h0);
		apb(1'h0, 12'h00C, 32'h0);
		`CHK("unmapped_rd", 32'h0, rd)
		`CHK("unmapped_err", 1'h1, er)
		// set the flag so the mid-run reset has something to clear
		apb(1'h1, `FSAM_CTRL_OFS, 32'h1);
		@(posedge pclk);
		presetn <= 1'h0;
		@(posedge pclk);
		#1;
		`CHK("pfc_upper_rst", 3'h2, pfc_upper_kseg_cache_attr)
		`CHK("rsp_rst", 1'h0, rsp_valid)
		`CHK("rsp_paddr_rst", 32'h0, rsp_paddr)
		`CHK("pready_rst", 1'h1, pready)
		@(posedge pclk);
		presetn <= 1'h1;
		apb(1'h0, `FSAM_CFG_OFS, 32'h0);
		`CHK("cfg_rst2", `FSAM_CFG_RST, rd)
		apb(1'h0, `FSAM_CTRL_OFS, 32'h0);
		`CHK("ctrl_rst", 32'h0, rd)
		stop_test();
	end
endmodule
